// file: core/tsc_params.svh
// Constants for the transmit timeslot indirect access block.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices and bus geometry
// ----------------------------------------------------------------------
`define TSC_IDX_CONFIG      8'h30
`define TSC_IDX_STATUS      8'h31
`define TSC_IDX_ADDR        8'h32
`define TSC_IDX_DATA        8'h33
`define TSC_IDX_SHIFT       2
`define TSC_ADDR_W          10
`define TSC_BE_LANE0        0

// ----------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------
`define TSC_CFG_PER_SLOT_CONTROL_ENABLE_BIT    0
`define TSC_CFG_IND_BIT     1
`define TSC_STAT_BUSY_BIT   7
`define TSC_ADDR_RNW_BIT    7
`define TSC_RST_BYTE        8'h00
`define TSC_RST_WORD        32'h0000_0000

// ----------------------------------------------------------------------
// Internal per-timeslot space
// ----------------------------------------------------------------------
`define TSC_INT_CTRL_LO     7'h20
`define TSC_INT_CTRL_HI     7'h3F
`define TSC_INT_IDLE_LO     7'h40
`define TSC_INT_IDLE_HI     7'h5F
`define TSC_MEM_DEPTH       64
`define TSC_IDLE_BASE       6'h20

// ----------------------------------------------------------------------
// Data control byte fields and inversion masks
// ----------------------------------------------------------------------
`define TSC_DC_SUBSTITUTION_SELECT_BIT     7
`define TSC_DC_DS0_BIT      6
`define TSC_DC_DS1_BIT      5
`define TSC_MASK_ODD        8'hAA
`define TSC_MASK_EVEN       8'h55
`define TSC_MASK_ALL        8'hFF
`define TSC_MASK_NONE       8'h00

// ----------------------------------------------------------------------
// Access timing
// ----------------------------------------------------------------------
`define TSC_CLK_PERIOD_NS   8
`define TSC_ACCESS_NS       480
`define TSC_ACCESS_CYCLES   (`TSC_ACCESS_NS / `TSC_CLK_PERIOD_NS)

`endif

// file: core/tsc_pkg.sv
// Types shared by the transmit timeslot indirect access block.
// Assumes tsc_params.svh is on the include path.
`default_nettype none

package tsc_pkg;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] idle;
	} tsc_slot_t;

	typedef enum logic [0:0] {
		TSC_ST_IDLE = 1'b0,
		TSC_ST_BUSY = 1'b1
	} tsc_state_t;

endpackage

`default_nettype wire

// file: core/tsc_indirect.sv
// Transmit timeslot controller with its indirect register access path.
// Assumes an Avalon-MM master on sys_clk_in and a transmit framer on the
// same clock that presents one timeslot byte per valid cycle.
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "tsc_params.svh"
`default_nettype none

module tsc_indirect (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_in,
	input  wire logic [`TSC_ADDR_W-1:0]   avs_address_in,
	input  wire logic                     avs_read_in,
	input  wire logic                     avs_write_in,
	input  wire logic [31:0]              avs_writedata_in,
	input  wire logic [3:0]               avs_byteenable_in,
	output logic      [31:0]              avs_readdata_out,
	output logic                          avs_waitrequest_out,
	input  wire logic                     tx_valid_in,
	input  wire logic [4:0]               tx_slot_in,
	input  wire logic [7:0]               tx_pcm_in,
	output logic                          tx_valid_out,
	output logic      [7:0]               tx_pcm_out,
	output tsc_pkg::tsc_slot_t            tx_slot_ctrl_out
);
	import tsc_pkg::*;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic       ind_en_reg;
	logic       per_slot_control_enable_reg;
	logic [7:0] addr_reg;
	logic [7:0] data_reg;
	logic [7:0] mem_q [`TSC_MEM_DEPTH];
	logic [5:0] count_reg;
	tsc_state_t state_reg;
	tsc_state_t state_next;
	logic       wait_reg;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire logic       bus_req;
	wire logic       bus_accept;
	wire logic [7:0] bus_idx;
	wire logic       idx_low_ok;
	wire logic       hit_cfg;
	wire logic       hit_stat;
	wire logic       hit_addr;
	wire logic       hit_data;
	wire logic       wr_ok;
	wire logic       wr_cfg;
	wire logic       wr_addr;
	wire logic       wr_data;
	wire logic       busy;

	assign bus_req    = avs_read_in | avs_write_in;
	// The answer is one cycle late: waitrequest starts high and falls for
	// exactly the edge at which the request is taken.
	assign bus_accept = bus_req & ~wait_reg;
	assign bus_idx    = avs_address_in[`TSC_ADDR_W-1:`TSC_IDX_SHIFT];
	assign idx_low_ok = avs_address_in[`TSC_IDX_SHIFT-1:0] == 2'b00;
	assign hit_cfg    = idx_low_ok & (bus_idx == `TSC_IDX_CONFIG);
	assign hit_stat   = idx_low_ok & (bus_idx == `TSC_IDX_STATUS);
	assign hit_addr   = idx_low_ok & (bus_idx == `TSC_IDX_ADDR);
	assign hit_data   = idx_low_ok & (bus_idx == `TSC_IDX_DATA);
	assign wr_ok      = bus_accept & avs_write_in
		& avs_byteenable_in[`TSC_BE_LANE0];
	assign wr_cfg     = wr_ok & hit_cfg;
	assign wr_addr    = wr_ok & hit_addr;
	assign wr_data    = wr_ok & hit_data;
	assign busy       = state_reg == TSC_ST_BUSY;

	// ------------------------------------------------------------------
	// Indirect access launch and completion
	// ------------------------------------------------------------------
	wire logic [6:0] new_int_addr;
	wire logic       new_addr_valid;
	wire logic       launch;
	wire logic       addr_take;
	wire logic [6:0] cur_int_addr;
	wire logic [5:0] mem_idx;
	wire logic       cur_rnw;
	wire logic       finish;
	wire logic       mem_wr;
	wire logic       buf_load;

	assign new_int_addr   = avs_writedata_in[6:0];
	assign new_addr_valid = (new_int_addr >= `TSC_INT_CTRL_LO)
		& (new_int_addr <= `TSC_INT_IDLE_HI);
	// An address write that lands during an access is dropped whole, so the access
	// in flight keeps its address and direction.
	assign addr_take    = wr_addr & ~busy;
	assign launch       = addr_take & new_addr_valid;
	assign cur_int_addr = addr_reg[6:0];
	assign cur_rnw      = addr_reg[`TSC_ADDR_RNW_BIT];
	assign mem_idx      = 6'(cur_int_addr - `TSC_INT_CTRL_LO);
	assign finish       = busy & (count_reg == 6'd0);
	assign mem_wr       = finish & ~cur_rnw;
	assign buf_load     = finish & cur_rnw;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			TSC_ST_IDLE: begin
				if (launch) begin
					state_next = TSC_ST_BUSY;
				end
			end
			TSC_ST_BUSY: begin
				if (finish) begin
					state_next = TSC_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= TSC_ST_IDLE;
			count_reg <= 6'd0;
		end else begin
			state_reg <= state_next;
			if (launch) begin
				count_reg <= 6'(`TSC_ACCESS_CYCLES - 1);
			end else if (busy) begin
				count_reg <= count_reg - 6'd1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ind_en_reg <= 1'b0;
			per_slot_control_enable_reg   <= 1'b0;
		end else if (wr_cfg) begin
			ind_en_reg <= avs_writedata_in[`TSC_CFG_IND_BIT];
			per_slot_control_enable_reg   <= avs_writedata_in[`TSC_CFG_PER_SLOT_CONTROL_ENABLE_BIT];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_reg <= `TSC_RST_BYTE;
		end else if (addr_take) begin
			addr_reg <= avs_writedata_in[7:0];
		end
	end

	// The buffer is frozen against software while busy; a read result
	// therefore never races a host write.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_reg <= `TSC_RST_BYTE;
		end else if (buf_load) begin
			data_reg <= mem_q[mem_idx];
		end else if (wr_data & ~busy) begin
			data_reg <= avs_writedata_in[7:0];
		end
	end

	// Per-timeslot bytes are not reset; software must program them.
	always_ff @(posedge sys_clk_in) begin
		if (mem_wr) begin
			mem_q[mem_idx] <= data_reg;
		end
	end

	// ------------------------------------------------------------------
	// Avalon-MM answer
	// ------------------------------------------------------------------
	wire logic [31:0] rd_mux;

	assign rd_mux =
		hit_cfg  ? {30'd0, ind_en_reg, per_slot_control_enable_reg} :
		hit_stat ? {24'd0, busy, 7'd0} :
		hit_addr ? {24'd0, addr_reg} :
		hit_data ? {24'd0, data_reg} :
		`TSC_RST_WORD;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_reg         <= 1'b1;
			avs_readdata_out <= `TSC_RST_WORD;
		end else begin
			wait_reg <= ~(bus_req & wait_reg);
			if (bus_req & wait_reg & avs_read_in) begin
				avs_readdata_out <= rd_mux;
			end
		end
	end

	assign avs_waitrequest_out = wait_reg;

	// ------------------------------------------------------------------
	// Transmit timeslot path
	// ------------------------------------------------------------------
	wire logic [7:0] slot_ctrl;
	wire logic [7:0] slot_idle;
	wire logic       substitution_select;
	wire logic       ds0;
	wire logic       ds1;
	wire logic [7:0] inv_mask;
	wire logic [7:0] pcm_mod;

	assign slot_ctrl = mem_q[{1'b0, tx_slot_in}];
	assign slot_idle = mem_q[`TSC_IDLE_BASE | {1'b0, tx_slot_in}];
	assign substitution_select      = slot_ctrl[`TSC_DC_SUBSTITUTION_SELECT_BIT];
	assign ds0       = slot_ctrl[`TSC_DC_DS0_BIT];
	assign ds1       = slot_ctrl[`TSC_DC_DS1_BIT];
	assign inv_mask  = (ds0 & ds1) ? `TSC_MASK_ALL :
		ds1 ? `TSC_MASK_ODD :
		ds0 ? `TSC_MASK_EVEN : `TSC_MASK_NONE;
	// Milliwatt tone selections leave the byte untouched; no tone source
	// exists here.
	assign pcm_mod   = ~per_slot_control_enable_reg ? tx_pcm_in :
		(substitution_select & ~ds0) ? slot_idle :
		substitution_select ? tx_pcm_in : (tx_pcm_in ^ inv_mask);

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_valid_out     <= 1'b0;
			tx_pcm_out       <= `TSC_RST_BYTE;
			tx_slot_ctrl_out <= '0;
		end else begin
			tx_valid_out <= tx_valid_in;
			tx_pcm_out   <= pcm_mod;
			if (per_slot_control_enable_reg) begin
				tx_slot_ctrl_out <= '{slot_ctrl, slot_idle};
			end else begin
				tx_slot_ctrl_out <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_busy_launch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		launch |=> busy ##1 busy)
		else $error("Valid address write did not raise busy.");

	a_busy_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(busy) |-> ##59 busy ##1 !busy)
		else $error("Access did not last exactly 60 cycles.");

	a_busy_status: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(bus_req & wait_reg & avs_read_in & hit_stat)
		|=> avs_readdata_out[`TSC_STAT_BUSY_BIT] == $past(busy))
		else $error("Status read did not show busy.");

	a_busy_drop: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(busy) |-> $past(count_reg) == 6'd0)
		else $error("Busy fell before the access ended.");

	a_ignore_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(busy & wr_addr) |=> $stable(addr_reg))
		else $error("Address write during busy was taken.");

	a_read_fill: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(finish & cur_rnw) |=> data_reg == mem_q[$past(mem_idx)])
		else $error("Read did not load the data buffer.");

	a_write_store: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(finish & ~cur_rnw) |=> mem_q[$past(mem_idx)] == $past(data_reg))
		else $error("Write did not store the data buffer.");

	a_ind_reset: assert property (@(posedge sys_clk_in)
		$fell(rst_in) |-> !ind_en_reg)
		else $error("Indirect enable not clear after reset.");

	a_per_slot_control_enable_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!per_slot_control_enable_reg |=> tx_pcm_out == $past(tx_pcm_in)
		&& tx_slot_ctrl_out == '0)
		else $error("Disabled controller altered transmit data.");

	a_per_slot_control_enable_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		per_slot_control_enable_reg |=> tx_slot_ctrl_out.ctrl == $past(slot_ctrl))
		else $error("Enabled controller did not deliver slot bytes.");

	a_idle_subst: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(per_slot_control_enable_reg & substitution_select & ~ds0) |=> tx_pcm_out == $past(slot_idle))
		else $error("Idle code was not substituted.");

	a_bad_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(addr_take & ~new_addr_valid) |=> !busy)
		else $error("Out-of-range address launched an access.");

	a_wait_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(bus_req & wait_reg) |=> !avs_waitrequest_out)
		else $error("Waitrequest held longer than one cycle.");

endmodule

`default_nettype wire

// file: tb/tsc_indirect_tb.sv
// Self-checking bench for the transmit timeslot indirect access block.
// Assumes the design sources are compiled first and that tsc_params.svh
// is on the include path.
`include "tsc_params.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tsc_pkg::*;

	// ------------------------------------------------------------------
	// Signals and constants
	// ------------------------------------------------------------------
	localparam int         LIMIT = 20000;
	localparam logic [9:0] A_CFG = {2'b00, `TSC_IDX_CONFIG} << 2;
	localparam logic [9:0] A_STA = {2'b00, `TSC_IDX_STATUS} << 2;
	localparam logic [9:0] A_ADR = {2'b00, `TSC_IDX_ADDR} << 2;
	localparam logic [9:0] A_DAT = {2'b00, `TSC_IDX_DATA} << 2;
	localparam logic [7:0] MODES [7] = '{8'h00, 8'h20, 8'h40, 8'h60,
		8'h80, 8'hA0, 8'hC0};
	localparam logic [7:0] EXPS [7] = '{8'h3C, 8'h96, 8'h69, 8'hC3,
		8'h5A, 8'h5A, 8'h3C};

	logic        sys_clk_in;
	logic        rst_in;
	logic        rd;
	logic        wr;
	logic [9:0]  addr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        wait_o;
	logic        tv_i;
	logic [4:0]  ts_i;
	logic [7:0]  pcm_i;
	logic        tv_o;
	logic [7:0]  pcm_o;
	tsc_slot_t   slot_o;
	logic [7:0]  rv;
	int          miscompares = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          t0;
	int          n;

	tsc_indirect u_tsc_indirect (
		.sys_clk_in          (sys_clk_in),
		.rst_in              (rst_in),
		.avs_address_in      (addr),
		.avs_read_in         (rd),
		.avs_write_in        (wr),
		.avs_writedata_in    (wdata),
		.avs_byteenable_in   (be),
		.avs_readdata_out    (rdata),
		.avs_waitrequest_out (wait_o),
		.tx_valid_in         (tv_i),
		.tx_slot_in          (ts_i),
		.tx_pcm_in           (pcm_i),
		.tx_valid_out        (tv_o),
		.tx_pcm_out          (pcm_o),
		.tx_slot_ctrl_out    (slot_o)
	);

	// ------------------------------------------------------------------
	// Clock, timeout and closing report
	// ------------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The counter updates by non-blocking assignment so that the tests
	// read a stable value in the time step of an edge.
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------
	// Bus and transmit tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The request is held until the edge at which waitrequest samples low.
	task automatic bus(input logic is_wr, input logic [9:0] a,
		input logic [7:0] d, input logic [3:0] en, output logic [7:0] q);
		int k;
		k = 0;
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= {24'h00_0000, d};
		be <= en;
		wr <= is_wr;
		rd <= !is_wr;
		do begin
			@(posedge sys_clk_in);
			k++;
		end while (wait_o !== 1'b0 && k < 100);
		if (k >= 100) begin
			miscompares++;
			$display("ERROR bus handshake expected %h seen %h", 1'b0, wait_o);
		end
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic wr8(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, 4'h1, q);
	endtask

	task automatic rd8(input logic [9:0] a, output logic [7:0] q);
		bus(1'b0, a, 8'h00, 4'h1, q);
	endtask

	task automatic wait_idle;
		logic [7:0] s;
		n = 0;
		do begin
			rd8(A_STA, s);
			n++;
		end while (s[7] !== 1'b0 && n < 100);
		if (n >= 100) begin
			miscompares++;
			$display("ERROR busy poll expected %h seen %h", 1'b0, s[7]);
		end
	endtask

	task automatic indirect_access_enable(input logic rnw, input logic [6:0] a);
		wr8(A_ADR, {rnw, a});
		wait_idle();
	endtask

	task automatic tx(input logic [4:0] s, input logic [7:0] p,
		input logic [7:0] ep, input logic [7:0] ec, input logic [7:0] ei);
		@(posedge sys_clk_in);
		tv_i <= 1'b1;
		ts_i <= s;
		pcm_i <= p;
		@(posedge sys_clk_in);
		tv_i <= 1'b0;
		#1;
		chk("tx_valid", 8'h01, {7'h00, tv_o});
		chk("tx_pcm", ep, pcm_o);
		chk("slot_ctrl", ec, slot_o.ctrl);
		chk("slot_idle", ei, slot_o.idle);
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		rst_in = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = '0;
		wdata = '0;
		be = '0;
		tv_i = 1'b0;
		ts_i = '0;
		pcm_i = '0;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd8(A_CFG + 10'(4 * i), rv);
			chk("reset value", 8'h00, rv);
		end
		rd8(10'h100, rv);
		chk("unmapped", 8'h00, rv);
		bus(1'b1, A_CFG, 8'h03, 4'h0, rv);
		rd8(A_CFG, rv);
		chk("config no lane", 8'h00, rv);
		wr8(A_CFG, 8'h02);
		rd8(A_CFG, rv);
		chk("config", 8'h02, rv);
		$display("test registers done");

		wr8(A_DAT, 8'h5A);
		wr8(A_ADR, 8'h45);
		t0 = cyc;
		rd8(A_STA, rv);
		chk("busy", 8'h80, rv & 8'h80);
		wait_idle();
		chk("access time", 8'h01, {7'h00, (cyc - t0) >=
			`TSC_ACCESS_CYCLES - 1 && (cyc - t0) <= `TSC_ACCESS_CYCLES + 8});
		wr8(A_DAT, 8'h00);
		indirect_access_enable(1'b1, 7'h45);
		rd8(A_DAT, rv);
		chk("read back", 8'h5A, rv);
		$display("test indirect done");

		wr8(A_ADR, 8'hC5);
		wr8(A_ADR, 8'h25);
		wr8(A_DAT, 8'h11);
		wait_idle();
		rd8(A_ADR, rv);
		chk("addr while busy", 8'hC5, rv);
		rd8(A_DAT, rv);
		chk("data while busy", 8'h5A, rv);
		wr8(A_ADR, 8'h90);
		rd8(A_STA, rv);
		chk("no launch", 8'h00, rv & 8'h80);
		$display("test busy done");

		tx(5'd5, 8'h3C, 8'h3C, 8'h00, 8'h00);
		// Slot 5 gets a known control byte before the controller is
		// enabled, so that no unwritten byte reaches the framer outputs.
		wr8(A_DAT, 8'h00);
		indirect_access_enable(1'b0, 7'h25);
		wr8(A_CFG, 8'h03);
		for (int i = 0; i < 7; i++) begin
			wr8(A_DAT, MODES[i]);
			indirect_access_enable(1'b0, 7'h25);
			tx(5'd5, 8'h3C, EXPS[i], MODES[i], 8'h5A);
		end
		wr8(A_DAT, 8'hE7);
		indirect_access_enable(1'b0, 7'h5F);
		wr8(A_DAT, 8'h80);
		indirect_access_enable(1'b0, 7'h3F);
		tx(5'd31, 8'h00, 8'hE7, 8'h80, 8'hE7);
		$display("test transmit done");
		complete_run();
	end

endmodule

`default_nettype wire
